// >>> hdl/htpsr_device.sv
`timescale 1ns/100ps
// Functional notes
// (RULE1) host reset: defaults, all pins high impedance
// (RULE2) controller holds reset high for operation
// (RULE3) test reset: defaults, test machine held reset
// (RULE4) reset released: test machine resumes sequencing
// (RULE5) mode high: pins form boundary-scan port
// (RULE6) mode low: pins form host interface
// (RULE7) host select pin active low
// (RULE8) test select pin is TMS, active high
// (RULE9) board ties select high when unused
// (RULE10) host output shifts register contents out
// (RULE11) test mode output pin is TDO
// (RULE12) reset restores defaults, restarts test sequence
// (RULE13) serial input: host data or TDI
// (RULE14) clock pin: host burst clock or TCK
// (RULE15) mode changes only between transfers
module htpsr_device
  import htpsr_pkg::*;
(
  htpsr_if.dev              lnk,
  input  wire logic         clk,
  input  wire logic         rstn,
  output logic [7:0]        cfg_word,
  output logic              cfg_valid,
  output logic              test_reset_state,
  output logic              in_test_mode,
  output logic              serial_video_output_oe
);
  import htpsr_pkg::*;

  typedef enum logic [3:0] {
    HTPSR_T_RESET,
    HTPSR_T_IDLE,
    HTPSR_T_SEL_DR,
    HTPSR_T_CAP_DR,
    HTPSR_T_SH_DR,
    HTPSR_T_EX1_DR,
    HTPSR_T_PAUSE_DR,
    HTPSR_T_EX2_DR,
    HTPSR_T_UPD_DR,
    HTPSR_T_SEL_IR,
    HTPSR_T_CAP_IR,
    HTPSR_T_SH_IR,
    HTPSR_T_EX1_IR,
    HTPSR_T_PAUSE_IR,
    HTPSR_T_EX2_IR,
    HTPSR_T_UPD_IR
  } htpsr_tap_st_t;

  // link side, clocked by the shared clock pin
  typedef struct packed {
    logic [7:0]   shift;
    logic [2:0]   cnt;
    logic [7:0]   word;
    logic         word_tgl;
    htpsr_tap_st_t tap;
    logic         out_bit;
    logic         out_oe;
  } htpsr_lnk_t;

  localparam htpsr_lnk_t LNK_RESET = '{
    shift:    SHIFT_RESET,
    cnt:      3'h0,
    word:     SHIFT_RESET,
    word_tgl: 1'b0,
    tap:      HTPSR_T_RESET,
    out_bit:  1'b0,
    out_oe:   1'b0
  };

  typedef struct packed {
    logic [2:0]   tgl_sync;
    logic [1:0]   rst_sync;
    logic [1:0]   mode_sync;
    logic [7:0]   cfg_word;
    logic         cfg_valid;
    logic         test_reset_state;
    logic         in_test_mode;
    logic         sdo_oe;
  } htpsr_sys_t;

  htpsr_lnk_t l_r, l_nxt;
  htpsr_sys_t s_r, s_nxt;

  wire logic test_mode = lnk.mode_test_pin;
  wire logic pin_rst_n = lnk.rst_n_pin;
  wire logic tms_pin   = lnk.shared_select_pin;

  always_comb begin
    l_nxt = l_r;
    if (!pin_rst_n) begin
      l_nxt = LNK_RESET; // [RULE12] [RULE3]
    end else if (test_mode == MODE_TEST) begin // [RULE5] [RULE4]
      // tms high for five clocks lands in reset from any state
      unique case (l_r.tap) // [RULE8]
        HTPSR_T_RESET: begin
          l_nxt.tap = tms_pin ? HTPSR_T_RESET : HTPSR_T_IDLE;
        end
        HTPSR_T_IDLE: begin
          l_nxt.tap = tms_pin ? HTPSR_T_SEL_DR : HTPSR_T_IDLE;
        end
        HTPSR_T_SEL_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_SEL_IR : HTPSR_T_CAP_DR;
        end
        HTPSR_T_CAP_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_EX1_DR : HTPSR_T_SH_DR;
        end
        HTPSR_T_SH_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_EX1_DR : HTPSR_T_SH_DR;
        end
        HTPSR_T_EX1_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_UPD_DR : HTPSR_T_PAUSE_DR;
        end
        HTPSR_T_PAUSE_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_EX2_DR : HTPSR_T_PAUSE_DR;
        end
        HTPSR_T_EX2_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_UPD_DR : HTPSR_T_SH_DR;
        end
        HTPSR_T_UPD_DR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_SEL_DR : HTPSR_T_IDLE;
        end
        HTPSR_T_SEL_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_RESET : HTPSR_T_CAP_IR;
        end
        HTPSR_T_CAP_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_EX1_IR : HTPSR_T_SH_IR;
        end
        HTPSR_T_SH_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_EX1_IR : HTPSR_T_SH_IR;
        end
        HTPSR_T_EX1_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_UPD_IR : HTPSR_T_PAUSE_IR;
        end
        HTPSR_T_PAUSE_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_EX2_IR : HTPSR_T_PAUSE_IR;
        end
        HTPSR_T_EX2_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_UPD_IR : HTPSR_T_SH_IR;
        end
        HTPSR_T_UPD_IR: begin
          l_nxt.tap = tms_pin ? HTPSR_T_SEL_DR : HTPSR_T_IDLE;
        end
      endcase
      // plain shift chain between tdi and tdo; no instruction decode behind it
      l_nxt.shift = {lnk.shared_serial_in_pin, l_r.shift[7:1]}; // [RULE13] [RULE14]
      l_nxt.cnt = 3'h0;
      l_nxt.out_bit = l_r.shift[0]; // [RULE11]
      l_nxt.out_oe = 1'b1;
    end else begin // [RULE6]
      if (!lnk.shared_select_pin) begin // [RULE7]
        l_nxt.shift = {l_r.shift[6:0], lnk.shared_serial_in_pin}; // [RULE13] [RULE14]
        l_nxt.cnt = 3'(l_r.cnt + 3'h1);
        l_nxt.out_bit = l_r.word[3'h7 - l_r.cnt]; // [RULE10]
        l_nxt.out_oe = 1'b1;
        if (l_r.cnt == 3'h7) begin
          l_nxt.word = {l_r.shift[6:0], lnk.shared_serial_in_pin};
          l_nxt.word_tgl = ~l_r.word_tgl;
        end
      end else begin
        l_nxt.cnt = 3'h0;
        l_nxt.out_oe = 1'b0;
      end
    end
  end

  // pin reset acts at once: the burst clock is parked between frames
  always_ff @(posedge lnk.shared_clk_pin or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      l_r <= LNK_RESET; // [RULE1] [RULE12]
    end else begin
      l_r <= l_nxt;
    end
  end

  assign lnk.shared_serial_out_pin = l_r.out_bit;
  // host output released as soon as the frame ends, not at the next clock
  assign lnk.shared_serial_out_oe  = l_r.out_oe & pin_rst_n & (test_mode | ~lnk.shared_select_pin); // [RULE1]

  always_comb begin
    s_nxt = s_r;
    s_nxt.tgl_sync = {s_r.tgl_sync[1:0], l_r.word_tgl};
    s_nxt.rst_sync = {s_r.rst_sync[0], pin_rst_n};
    s_nxt.mode_sync = {s_r.mode_sync[0], test_mode};
    s_nxt.cfg_valid = s_r.tgl_sync[2] ^ s_r.tgl_sync[1];
    if (s_r.tgl_sync[2] ^ s_r.tgl_sync[1]) begin
      s_nxt.cfg_word = l_r.word; // word stable for many link cycles after toggle
    end
    s_nxt.in_test_mode = s_r.mode_sync[1];
    s_nxt.test_reset_state = s_r.mode_sync[1] & ~s_r.rst_sync[1]; // [RULE3]
    s_nxt.sdo_oe = s_r.rst_sync[1]; // [RULE1]
    if (!s_r.rst_sync[1]) begin
      s_nxt.cfg_word = SHIFT_RESET; // [RULE12]
      s_nxt.cfg_valid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg_word               = s_r.cfg_word;
  assign cfg_valid              = s_r.cfg_valid;
  assign test_reset_state       = s_r.test_reset_state;
  assign in_test_mode           = s_r.in_test_mode;
  assign serial_video_output_oe = s_r.sdo_oe;
endmodule : htpsr_device

// >>> hdl/htpsr_pkg.sv
package htpsr_pkg;
  localparam logic       MODE_HOST     = 1'b0;
  localparam logic       MODE_TEST     = 1'b1;
  localparam logic       SEL_IDLE      = 1'b1;
  localparam logic       RST_INACTIVE  = 1'b1;
  localparam logic       SER_IDLE      = 1'b1;
  localparam logic [7:0] SHIFT_RESET   = 8'h00;
  localparam int         DIV_HALF      = 4;
  localparam logic [2:0] DIV_LAST      = 3'(DIV_HALF - 1);
  typedef enum logic [1:0] {HTPSR_IDLE, HTPSR_SHIFT, HTPSR_DONE} htpsr_host_st_t;
endpackage : htpsr_pkg

// >>> hdl/htpsr_if.sv
`timescale 1ns/100ps
interface htpsr_if;
  logic rst_n_pin;
  logic mode_test_pin;
  logic shared_select_pin;
  logic shared_serial_in_pin;
  logic shared_clk_pin;
  logic shared_serial_out_pin;
  logic shared_serial_out_oe;
  modport dev  (input rst_n_pin, mode_test_pin, shared_select_pin, shared_serial_in_pin, shared_clk_pin,
                output shared_serial_out_pin, shared_serial_out_oe);
  modport ctrl (output rst_n_pin, mode_test_pin, shared_select_pin, shared_serial_in_pin, shared_clk_pin,
                input shared_serial_out_pin, shared_serial_out_oe);
endinterface : htpsr_if

// >>> hdl/htpsr_ctrl.sv
`timescale 1ns/100ps
module htpsr_ctrl
  import htpsr_pkg::*;
(
  htpsr_if.ctrl             lnk,
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         req_mode_test,
  input  wire logic         req_dev_reset,
  input  wire logic         start,
  input  wire logic [7:0]   wdata,
  output logic              busy,
  output logic [7:0]        rdata,
  output logic              done
);
  import htpsr_pkg::*;

  typedef struct packed {
    htpsr_host_st_t st;
    logic [2:0]   div;
    logic         sclk;
    logic [3:0]   bits;
    logic [7:0]   tx;
    logic [7:0]   rx;
    logic [1:0]   din_sync;
    logic         mode;
    logic         rst_n;
    logic         sel;
    logic         done;
  } htpsr_ctl_t;

  htpsr_ctl_t c_r, c_nxt;
  logic       lnk_rise;

  // mode and reset move only off a rising link edge, so the device sees them settled
  assign lnk_rise = (c_r.div == DIV_LAST) && !c_r.sclk && (c_r.st == HTPSR_SHIFT || c_r.mode == MODE_TEST);

  always_comb begin
    c_nxt = c_r;
    c_nxt.done = 1'b0;
    c_nxt.din_sync = {c_r.din_sync[0], lnk.shared_serial_out_pin};
    if (!lnk_rise) begin
      c_nxt.rst_n = ~req_dev_reset; // [RULE2]
    end
    // burst clock parks low outside frames; test clock runs free
    if (c_r.st == HTPSR_SHIFT || c_r.mode == MODE_TEST) begin
      c_nxt.div = (c_r.div == DIV_LAST) ? 3'h0 : 3'(c_r.div + 3'h1);
      if (c_r.div == DIV_LAST) begin
        c_nxt.sclk = ~c_r.sclk; // [RULE14]
      end
    end else begin
      c_nxt.div = 3'h0;
      c_nxt.sclk = 1'b0;
    end
    unique case (c_r.st)
      HTPSR_IDLE: begin
        c_nxt.sel = SEL_IDLE; // [RULE9]
        if (!lnk_rise) begin
          c_nxt.mode = req_mode_test; // [RULE15]
        end
        if (start && c_r.mode == MODE_HOST) begin
          c_nxt.st = HTPSR_SHIFT;
          c_nxt.tx = wdata;
          c_nxt.bits = 4'h0;
        end
      end
      HTPSR_SHIFT: begin
        c_nxt.sel = 1'b0; // [RULE7]
        if (c_r.div == DIV_LAST && c_r.sclk) begin
          c_nxt.tx = {c_r.tx[6:0], 1'b0}; // [RULE13]
          c_nxt.rx = {c_r.rx[6:0], c_r.din_sync[1]}; // [RULE10]
          c_nxt.bits = 4'(c_r.bits + 4'h1);
          if (c_r.bits == 4'h7) begin
            c_nxt.st = HTPSR_DONE;
          end
        end
      end
      HTPSR_DONE: begin
        c_nxt.sel = SEL_IDLE;
        c_nxt.done = 1'b1;
        c_nxt.st = HTPSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      c_r <= '0;
      c_r.sel <= SEL_IDLE;
      c_r.rst_n <= RST_INACTIVE;
      c_r.st <= HTPSR_IDLE;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign lnk.shared_clk_pin       = c_r.sclk;
  assign lnk.shared_select_pin    = c_r.sel;
  assign lnk.shared_serial_in_pin = c_r.tx[7];
  assign lnk.mode_test_pin        = c_r.mode;
  assign lnk.rst_n_pin            = c_r.rst_n;
  assign busy                     = (c_r.st != HTPSR_IDLE);
  assign rdata                    = c_r.rx;
  assign done                     = c_r.done;
endmodule : htpsr_ctrl

// >>> test/htpsr_assertions.sv
`timescale 1ns/100ps
module htpsr_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rst_n_pin,
  input wire logic mode_test_pin,
  input wire logic shared_select_pin,
  input wire logic shared_serial_in_pin,
  input wire logic shared_clk_pin,
  input wire logic shared_serial_out_oe
);
  logic [3:0] rise_cnt_r;
  // link clock rises seen inside one host frame
  always_ff @(posedge clk) begin
    if (!rstn || shared_select_pin) rise_cnt_r <= 4'h0;
    else if ($rose(shared_clk_pin)) rise_cnt_r <= rise_cnt_r + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  oe_reset_off_a: assert property (!rst_n_pin |-> !shared_serial_out_oe)
    else $error("serial output enabled during pin reset");
  ctrl_reset_idle_a: assert property (disable iff (1'b0) !rstn |=> rst_n_pin && shared_select_pin)
    else $error("controller pins not idle after reset");
  frame_live_a: assert property (!shared_select_pin && !mode_test_pin |-> rst_n_pin)
    else $error("device reset during host frame");
  mode_idle_a: assert property ($rose(mode_test_pin) |-> $past(shared_select_pin))
    else $error("mode switched inside host frame");
  frame_bits_a: assert property ($rose(shared_select_pin) && !mode_test_pin |-> rise_cnt_r == 4'h8)
    else $error("host frame without eight clocks");
  clk_high_a: assert property ($rose(shared_clk_pin) && !shared_select_pin |-> shared_clk_pin[*4])
    else $error("link clock high half too short");
  clk_low_a: assert property ($fell(shared_clk_pin) && !shared_select_pin |-> !shared_clk_pin[*4])
    else $error("link clock low half too short");
  host_serial_input_settled_a: assert property ($changed(shared_serial_in_pin) && !shared_select_pin && !$past(shared_select_pin)
    |-> !shared_clk_pin) else $error("serial input moved while clock high");
  cover property ($rose(shared_select_pin) && !mode_test_pin);
  cover property ($fell(rst_n_pin));
  cover property ($rose(mode_test_pin));
endmodule : htpsr_assertions

// >>> test/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; $display("FAIL %0t %h %h", $time, a, b); end end
module tb_top;
  import htpsr_pkg::*;
  logic       clk, dclk, rstn, req_mode_test, req_dev_reset, start, busy, done, got_valid;
  logic       cfg_valid, test_reset_state, in_test_mode, serial_video_output_oe;
  logic [7:0] wdata, rdata, cfg_word;
  int         num_errors = 0;
  int         samples_checked = 0;
  htpsr_if lnk ();
  htpsr_device i_htpsr_device (.lnk(lnk.dev), .clk(dclk), .rstn, .cfg_word, .cfg_valid, .test_reset_state,
    .in_test_mode, .serial_video_output_oe);
  htpsr_ctrl i_htpsr_ctrl (.lnk(lnk.ctrl), .clk, .rstn, .req_mode_test, .req_dev_reset, .start, .wdata, .busy,
    .rdata, .done);
  htpsr_assertions i_htpsr_assertions (.clk, .rstn, .rst_n_pin(lnk.rst_n_pin), .mode_test_pin(lnk.mode_test_pin),
    .shared_select_pin(lnk.shared_select_pin), .shared_serial_in_pin(lnk.shared_serial_in_pin),
    .shared_clk_pin(lnk.shared_clk_pin), .shared_serial_out_oe(lnk.shared_serial_out_oe));
  initial begin clk = 1'b0; forever #4 clk = ~clk; end
  // device clock offset so no edge lines up with the controller's
  initial begin dclk = 1'b0; #1.3; forever #3 dclk = ~dclk; end
  always @(posedge dclk) if (cfg_valid === 1'b1) got_valid <= 1'b1;
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask : cyc
  task automatic xfer(input logic [7:0] w);
    got_valid = 1'b0; wdata = w; start = 1'b1; cyc(1); start = 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) cyc(1);
    `CHK(done, 1'b1)
    cyc(20);
  endtask : xfer
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin #100000; num_errors++; finish_test(); end
  initial begin
    {rstn, req_mode_test, start, wdata, got_valid} = '0;
    req_dev_reset = 1'b1;
    cyc(8); rstn = 1'b1; cyc(4);
    req_dev_reset = 1'b0; cyc(8); `CHK(serial_video_output_oe, 1'b1)
    xfer(8'ha5); `CHK(cfg_word, 8'ha5)
    `CHK(got_valid, 1'b1)
    xfer(8'h3c); `CHK(rdata, 8'ha5)
    $display("host transfer test done");
    req_dev_reset = 1'b1; cyc(20); `CHK(serial_video_output_oe, 1'b0)
    `CHK(cfg_word, SHIFT_RESET)
    req_dev_reset = 1'b0; cyc(20); `CHK(serial_video_output_oe, 1'b1)
    $display("host reset test done");
    req_mode_test = 1'b1; cyc(20); `CHK(in_test_mode, 1'b1)
    `CHK(lnk.shared_serial_out_oe, 1'b1)
    start = 1'b1; cyc(1); start = 1'b0; cyc(4); `CHK(busy, 1'b0)
    req_dev_reset = 1'b1; cyc(20); `CHK(test_reset_state, 1'b1)
    `CHK(lnk.shared_serial_out_oe, 1'b0)
    req_dev_reset = 1'b0; cyc(20); `CHK(test_reset_state, 1'b0)
    req_mode_test = 1'b0; cyc(20); `CHK(in_test_mode, 1'b0)
    xfer(8'h81); `CHK(cfg_word, 8'h81)
    `CHK(rdata, SHIFT_RESET)
    $display("mode switch test done");
    finish_test();
  end
endmodule : tb_top
